// *** hdl/codec_regs.svh ***
// Notes on behaviour
// - Float pin low, when so selected, releases every receive-side output.
// - A configuration input stops transmit enable from echoing onto carrier.
// - At 100 Mbps each host nibble becomes its 5-bit data code group.
// - First two preamble nibbles are replaced by start pair 11000, 10001.
// - Every 100 Mbps frame ends with the end pair 01101 then 00111.
// - Between frames at 100 Mbps the idle group 11111 is sent continuously.
// - Transmit error during a 100 Mbps frame sends halt in place of that nibble.
// - Received data code groups are turned back into their nibbles.
// - Undefined received code groups deliver nibble 0000.
// - A received start pair is delivered as two 0101 nibbles.
// - A received end pair is delivered as two 0000 nibbles.
// - Start, end and code errors raise sticky status bits and rx_er; idle inside a frame sets the end bit without rx_er.
// - At 10 Mbps each bit goes out inverted half first, true half second.
// - At 10 Mbps a start of idle pulse ends each frame; idle stays unencoded.
// - At 10 Mbps bi-phase halves become plain bits; idle pulse removed.
// - Bypass passes host 5-bit words unaltered; five-bit mode selects it at 100 Mbps only.
// - Bypass passes received words unaltered; carrier follows link pass.
// - Five-bit mode: error pins carry bit four, enable ignored, col invalid.
// - Receive clock follows transmit clock until lock, then recovered clock.
// - Received serial bits are assembled into words at recovered bit rate.
// - 10 Mbps nibble clock is 4 bits; no received preamble nibble is dropped.
// - Scramble transmitted groups at 100 Mbps only.
`ifndef CODEC_REGS_SVH
`define CODEC_REGS_SVH
`define SYM_IDLE 5'h1F
`define SYM_SSD1 5'h18
`define SYM_SSD2 5'h11
`define SYM_ESD1 5'h0D
`define SYM_ESD2 5'h07
`define SYM_HALT 5'h04
`define NIB_SSD 4'h5
`define NIB_ESD 4'h0
`define NIB_BAD 4'h0
`define SCR_SEED 11'h7FF
`define TX_SREG_RST 8'hF8
`define GRP_LAST 3'h4
`define HALF_LAST 3'h7
`define SOI_HALVES_DEF 4
`endif

// *** hdl/codec_pkg.sv ***
package codec_pkg;
  typedef enum logic [6:0] {
    TX_IDLE = 7'b0000001,
    TX_J    = 7'b0000010,
    TX_K    = 7'b0000100,
    TX_DATA = 7'b0001000,
    TX_T    = 7'b0010000,
    TX_R    = 7'b0100000,
    TX_SOI  = 7'b1000000
  } tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_DATA = 3'b010,
    RX_DONE = 3'b100
  } rx_state_e;
endpackage : codec_pkg

// *** hdl/bit_sync.sv ***
`timescale 1ns/100ps
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // The first stage feeds only the second, never any other logic.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_r[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta_r[i] <= d[i];
        q[i] <= meta_r[i];
      end
    end
  end
endmodule : bit_sync

// *** hdl/fast_ethernet_symbol_codec.sv ***
`timescale 1ns/100ps
`include "codec_regs.svh"
module fast_ethernet_symbol_codec #(
  parameter int SOI_HALVES = `SOI_HALVES_DEF
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Configuration and status.
  input wire logic speed_100,
  input wire logic five_bit_host_mode,
  input wire logic transmit_carrier_echo_off,
  input wire logic float_pin_select,
  input wire logic status_clr,
  output logic ssd_err_r,
  output logic esd_err_r,
  output logic code_err_r,
  // Line side.
  input wire logic line_clk,
  input wire logic rx_line_bit,
  input wire logic rx_locked,
  input wire logic link_pass,
  output logic tx_line_r,
  output logic tx_drive_r,
  // Host side.
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  input wire logic receive_float_or_jam_pin,
  output logic tx_clk,
  output logic rx_clk,
  output logic [3:0] rxd_r,
  output logic rx_dv_r,
  output logic rx_er_r,
  output logic crs,
  output logic col,
  output logic rx_oe
);
  if (SOI_HALVES < 1 || SOI_HALVES > 8) begin : g_bad_soi
    $error("SOI_HALVES must lie between 1 and 8");
  end

  function automatic logic [4:0] enc(input logic [3:0] n);
    logic [4:0] c;
    c = 5'h1E;
    case (n)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      default: c = 5'h1D;
    endcase
    return c;
  endfunction : enc

  // Returns a valid flag above the nibble; undefined groups give 0000.
  function automatic logic [4:0] dec(input logic [4:0] c);
    logic [4:0] r;
    r = {1'b0, `NIB_BAD};
    for (int i = 0; i < 16; i++) begin
      if (enc(4'(i)) == c) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : dec

  // Host tx inputs, line clock and line status all come from other domains.
  logic [11:0] sync_q;
  logic lclk_s, rxbit_s, lock_s, link_s, txen_s, txer_s, pin_s;
  logic [3:0] txd_s;
  bit_sync #(.W(12)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({line_clk, rx_line_bit, rx_locked, link_pass, tx_en, tx_er,
        receive_float_or_jam_pin, txd, 1'b0}),
    .q(sync_q)
  );
  assign {lclk_s, rxbit_s, lock_s, link_s, txen_s, txer_s, pin_s, txd_s} =
    sync_q[11:1];

  logic lclk_d_r;
  logic bit_tick;
  logic bypass;
  logic [2:0] last_cnt;
  assign bit_tick = lclk_s & ~lclk_d_r;
  assign bypass = five_bit_host_mode & speed_100;
  assign last_cnt = speed_100 ? `GRP_LAST : `HALF_LAST;

  // Transmit path.
  codec_pkg::tx_state_e tx_st_r, tx_st_nxt;
  logic [2:0] tcnt_r, tcnt_nxt;
  logic [7:0] sreg_r, sreg_nxt, dmask_r, dmask_nxt;
  logic [10:0] lfsr_r, lfsr_nxt;
  logic [4:0] code_r, code_nxt;
  logic tx_line_nxt, tx_drive_nxt, fb, nib_tick;
  assign fb = lfsr_r[10] ^ lfsr_r[8];
  assign nib_tick = bit_tick && tcnt_r == last_cnt;

  always_comb begin
    tx_st_nxt = tx_st_r;
    tcnt_nxt = tcnt_r;
    sreg_nxt = sreg_r;
    dmask_nxt = dmask_r;
    lfsr_nxt = lfsr_r;
    code_nxt = code_r;
    tx_line_nxt = tx_line_r;
    tx_drive_nxt = tx_drive_r;
    if (bit_tick) begin
      // Scramble only at 100 Mbps; 10 Mbps halves go out as they are.
      tx_line_nxt = sreg_r[7] ^ (fb & speed_100);
      tx_drive_nxt = dmask_r[7];
      if (speed_100) begin
        lfsr_nxt = {lfsr_r[9:0], fb};
      end
      sreg_nxt = {sreg_r[6:0], 1'b0};
      dmask_nxt = {dmask_r[6:0], 1'b0};
      tcnt_nxt = tcnt_r + 3'h1;
      if (tcnt_r == last_cnt) begin
        tcnt_nxt = 3'h0;
        if (bypass) begin
          code_nxt = {txer_s, txd_s};
          tx_st_nxt = codec_pkg::TX_IDLE;
        end else if (speed_100) begin
          case (tx_st_r)
            codec_pkg::TX_IDLE: begin
              code_nxt = `SYM_IDLE;
              if (txen_s) begin
                code_nxt = `SYM_SSD1;
                tx_st_nxt = codec_pkg::TX_J;
              end
            end
            codec_pkg::TX_J: begin
              code_nxt = `SYM_SSD2;
              tx_st_nxt = codec_pkg::TX_K;
            end
            codec_pkg::TX_K, codec_pkg::TX_DATA: begin
              if (txen_s) begin
                code_nxt = txer_s ? `SYM_HALT : enc(txd_s);
                tx_st_nxt = codec_pkg::TX_DATA;
              end else begin
                code_nxt = `SYM_ESD1;
                tx_st_nxt = codec_pkg::TX_T;
              end
            end
            codec_pkg::TX_T: begin
              code_nxt = `SYM_ESD2;
              tx_st_nxt = codec_pkg::TX_R;
            end
            default: begin
              code_nxt = `SYM_IDLE;
              tx_st_nxt = codec_pkg::TX_IDLE;
            end
          endcase
        end
        if (speed_100) begin
          sreg_nxt = {code_nxt, 3'h0};
          dmask_nxt = 8'hFF;
        end else begin
          // Idle carries no encoded data; link pulses come from elsewhere.
          dmask_nxt = 8'h00;
          sreg_nxt = 8'h00;
          if (txen_s) begin
            tx_st_nxt = codec_pkg::TX_DATA;
            dmask_nxt = 8'hFF;
            for (int b = 0; b < 4; b++) begin
              sreg_nxt[7-2*b] = ~txd_s[b];
              sreg_nxt[6-2*b] = txd_s[b];
            end
          end else if (tx_st_r == codec_pkg::TX_DATA) begin
            tx_st_nxt = codec_pkg::TX_SOI;
            sreg_nxt = 8'hFF;
            dmask_nxt = 8'hFF << (8 - SOI_HALVES);
          end else begin
            tx_st_nxt = codec_pkg::TX_IDLE;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lclk_d_r <= 1'b0;
      tx_st_r <= codec_pkg::TX_IDLE;
      tcnt_r <= 3'h0;
      sreg_r <= `TX_SREG_RST;
      dmask_r <= 8'h00;
      lfsr_r <= `SCR_SEED;
      code_r <= `SYM_IDLE;
      tx_line_r <= 1'b0;
      tx_drive_r <= 1'b0;
    end else begin
      lclk_d_r <= lclk_s;
      tx_st_r <= tx_st_nxt;
      tcnt_r <= tcnt_nxt;
      sreg_r <= sreg_nxt;
      dmask_r <= dmask_nxt;
      lfsr_r <= lfsr_nxt;
      code_r <= code_nxt;
      tx_line_r <= tx_line_nxt;
      tx_drive_r <= tx_drive_nxt;
    end
  end

  // Receive path.
  codec_pkg::rx_state_e rx_st_r, rx_st_nxt;
  logic [2:0] rcnt_r, rcnt_nxt;
  logic [7:0] rsh_r, rsh_nxt;
  logic [4:0] prev_r, prev_nxt, cur, dp;
  logic prev_v_r, prev_v_nxt, pend_r, pend_nxt, pend_end_r, pend_end_nxt;
  logic [3:0] pend_val_r, pend_val_nxt, rxd_nxt, nib10;
  logic rx_dv_nxt, rx_er_nxt, viol, set_ssd, set_esd, set_code;

  always_comb begin
    rx_st_nxt = rx_st_r;
    rcnt_nxt = rcnt_r;
    rsh_nxt = rsh_r;
    prev_nxt = prev_r;
    prev_v_nxt = prev_v_r;
    pend_nxt = pend_r;
    pend_end_nxt = pend_end_r;
    pend_val_nxt = pend_val_r;
    rxd_nxt = rxd_r;
    rx_dv_nxt = rx_dv_r;
    rx_er_nxt = rx_er_r;
    set_ssd = 1'b0;
    set_esd = 1'b0;
    set_code = 1'b0;
    cur = rsh_nxt[4:0];
    dp = dec(prev_r);
    viol = 1'b0;
    nib10 = 4'h0;
    if (!lock_s) begin
      rx_st_nxt = codec_pkg::RX_IDLE;
      rcnt_nxt = 3'h0;
      prev_v_nxt = 1'b0;
      pend_nxt = 1'b0;
      rxd_nxt = 4'h0;
      rx_dv_nxt = 1'b0;
      rx_er_nxt = 1'b0;
    end else if (bit_tick) begin
      rsh_nxt = {rsh_r[6:0], rxbit_s};
      cur = rsh_nxt[4:0];
      rcnt_nxt = rcnt_r + 3'h1;
      if (rcnt_r == last_cnt) begin
        rcnt_nxt = 3'h0;
        rxd_nxt = 4'h0;
        rx_dv_nxt = 1'b0;
        rx_er_nxt = 1'b0;
        if (bypass) begin
          {rx_er_nxt, rxd_nxt} = cur;
        end else if (speed_100) begin
          // One group of look-ahead decides each delimiter pair.
          prev_nxt = cur;
          prev_v_nxt = 1'b1;
          if (!prev_v_r) begin
            rx_st_nxt = codec_pkg::RX_IDLE;
          end else if (pend_r) begin
            pend_nxt = 1'b0;
            rxd_nxt = pend_val_r;
            rx_dv_nxt = 1'b1;
            if (pend_end_r) begin
              rx_st_nxt = codec_pkg::RX_IDLE;
            end
          end else if (rx_st_r == codec_pkg::RX_IDLE) begin
            if (prev_r == `SYM_SSD1) begin
              if (cur == `SYM_SSD2) begin
                rxd_nxt = `NIB_SSD;
                rx_dv_nxt = 1'b1;
                pend_nxt = 1'b1;
                pend_val_nxt = `NIB_SSD;
                pend_end_nxt = 1'b0;
                rx_st_nxt = codec_pkg::RX_DATA;
              end else begin
                rx_er_nxt = 1'b1;
                set_ssd = 1'b1;
              end
            end
          end else if (prev_r == `SYM_ESD1) begin
            rx_dv_nxt = 1'b1;
            rxd_nxt = `NIB_ESD;
            if (cur == `SYM_ESD2) begin
              pend_nxt = 1'b1;
              pend_val_nxt = `NIB_ESD;
              pend_end_nxt = 1'b1;
            end else begin
              rx_er_nxt = 1'b1;
              set_esd = 1'b1;
              rx_st_nxt = codec_pkg::RX_IDLE;
            end
          end else if (prev_r == `SYM_IDLE) begin
            // Idle inside a frame means the end pair was lost.
            set_esd = 1'b1;
            rx_st_nxt = codec_pkg::RX_IDLE;
          end else begin
            rx_dv_nxt = 1'b1;
            rxd_nxt = dp[3:0];
            if (!dp[4]) begin
              rx_er_nxt = 1'b1;
              set_code = 1'b1;
            end
          end
        end else begin
          // A pair of equal halves is the start of idle pulse, not data.
          for (int b = 0; b < 4; b++) begin
            nib10[b] = rsh_nxt[6-2*b];
            viol = viol | (rsh_nxt[7-2*b] == rsh_nxt[6-2*b]);
          end
          if (rx_st_r != codec_pkg::RX_DONE) begin
            if (viol) begin
              rx_st_nxt = codec_pkg::RX_DONE;
            end else begin
              rx_st_nxt = codec_pkg::RX_DATA;
              rx_dv_nxt = 1'b1;
              rxd_nxt = nib10;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= codec_pkg::RX_IDLE;
      rcnt_r <= 3'h0;
      rsh_r <= 8'h00;
      prev_r <= `SYM_IDLE;
      prev_v_r <= 1'b0;
      pend_r <= 1'b0;
      pend_end_r <= 1'b0;
      pend_val_r <= 4'h0;
      rxd_r <= 4'h0;
      rx_dv_r <= 1'b0;
      rx_er_r <= 1'b0;
      ssd_err_r <= 1'b0;
      esd_err_r <= 1'b0;
      code_err_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rcnt_r <= rcnt_nxt;
      rsh_r <= rsh_nxt;
      prev_r <= prev_nxt;
      prev_v_r <= prev_v_nxt;
      pend_r <= pend_nxt;
      pend_end_r <= pend_end_nxt;
      pend_val_r <= pend_val_nxt;
      rxd_r <= rxd_nxt;
      rx_dv_r <= rx_dv_nxt;
      rx_er_r <= rx_er_nxt;
      // A new error in the clearing cycle still sets its bit.
      ssd_err_r <= set_ssd | (ssd_err_r & ~status_clr);
      esd_err_r <= set_esd | (esd_err_r & ~status_clr);
      code_err_r <= set_code | (code_err_r & ~status_clr);
    end
  end

  logic tx_busy, rx_busy;
  assign tx_busy = tx_st_r != codec_pkg::TX_IDLE;
  assign rx_busy = rx_dv_r | (rx_st_r == codec_pkg::RX_DATA);
  assign tx_clk = tcnt_r < 3'(2 + !speed_100 * 2);
  assign rx_clk = lock_s ? (rcnt_r < 3'(2 + !speed_100 * 2)) : tx_clk;
  assign crs = bypass ? link_s
             : (rx_busy | (tx_busy & ~transmit_carrier_echo_off));
  assign col = ~bypass & tx_busy & rx_busy;
  assign rx_oe = ~(float_pin_select & ~pin_s);

  chk_float_release: assert property (@(posedge clk) disable iff (!rst_n)
    float_pin_select && !pin_s |-> !rx_oe)
    else $error("receive outputs driven while float pin low");
  chk_echo_off: assert property (@(posedge clk) disable iff (!rst_n)
    transmit_carrier_echo_off && !bypass && !rx_busy |-> !crs)
    else $error("carrier echoed transmit enable while disabled");
  chk_echo_on: assert property (@(posedge clk) disable iff (!rst_n)
    !transmit_carrier_echo_off && !bypass && tx_busy |-> crs)
    else $error("carrier missing while transmitting");
  sequence seq_frame_start;
    nib_tick && speed_100 && !bypass && tx_st_r == codec_pkg::TX_IDLE &&
    txen_s;
  endsequence
  sequence seq_k_slot;
    nib_tick && speed_100 && !bypass && tx_st_r == codec_pkg::TX_J;
  endsequence
  chk_ssd_first: assert property (@(posedge clk) disable iff (!rst_n)
    seq_frame_start |=> code_r == `SYM_SSD1 &&
    tx_st_r == codec_pkg::TX_J)
    else $error("first start symbol not sent");
  chk_ssd_pair: assert property (@(posedge clk) disable iff (!rst_n)
    seq_k_slot |=> code_r == `SYM_SSD2)
    else $error("second start symbol not sent");
  sequence seq_esd_slot;
    nib_tick && speed_100 && !bypass && tx_st_r == codec_pkg::TX_T;
  endsequence
  chk_esd_pair: assert property (@(posedge clk) disable iff (!rst_n)
    seq_esd_slot |=> code_r == `SYM_ESD2 && tx_st_r == codec_pkg::TX_R)
    else $error("second end symbol not sent");
  chk_idle_fill: assert property (@(posedge clk) disable iff (!rst_n)
    nib_tick && speed_100 && !bypass && tx_st_r == codec_pkg::TX_R
    |=> code_r == `SYM_IDLE)
    else $error("idle not sent after end pair");
  chk_halt_sub: assert property (@(posedge clk) disable iff (!rst_n)
    nib_tick && speed_100 && !bypass && txen_s && txer_s &&
    tx_st_r == codec_pkg::TX_DATA |=> code_r == `SYM_HALT)
    else $error("halt not substituted on transmit error");
  chk_err_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    rx_er_r && !bypass && speed_100 && !$past(rx_er_r)
    |-> ssd_err_r || esd_err_r || code_err_r)
    else $error("receive error without status bit");
  chk_status_hold: assert property (@(posedge clk) disable iff (!rst_n)
    code_err_r && !status_clr |=> code_err_r)
    else $error("code error bit lost without clear");
endmodule : fast_ethernet_symbol_codec

// *** bench/mac_model.sv ***
`timescale 1ns/100ps
module mac_model (
  // Host transmit interface.
  input wire logic tx_clk,
  output logic [3:0] txd,
  output logic tx_en,
  output logic tx_er
);
  initial begin
    txd = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
  end
  // Each nibble changes just after the rising nibble clock edge.
  task automatic send(input logic [3:0] nib[$], input int er_at);
    foreach (nib[i]) begin
      @(posedge tx_clk);
      #10;
      txd = nib[i];
      tx_en = 1'b1;
      tx_er = (i == er_at);
    end
    @(posedge tx_clk);
    #10;
    tx_en = 1'b0;
    tx_er = 1'b0;
    // Released data shows the inverse so a stale value cannot look valid.
    txd = ~txd;
  endtask : send
  task automatic word(input logic [4:0] w);
    @(posedge tx_clk);
    #10;
    {tx_er, txd} = w;
  endtask : word
endmodule : mac_model

// *** bench/fast_ethernet_symbol_codec_tb_top.sv ***
`timescale 1ns/100ps
`include "codec_regs.svh"
module fast_ethernet_symbol_codec_tb_top;
  localparam int SOI = 3;
  logic clk = 0, rst_n = 0, speed_100 = 1, five_bit_host_mode = 0;
  logic transmit_carrier_echo_off = 0, float_pin_select = 0;
  logic status_clr = 0, line_clk = 0, rx_line_bit = 1, rx_locked = 0;
  logic link_pass = 0, receive_float_or_jam_pin = 1;
  logic ssd_err_r, esd_err_r, code_err_r, tx_line_r, tx_drive_r;
  logic tx_clk, rx_clk, rx_dv_r, rx_er_r, crs, col, rx_oe, tx_en, tx_er;
  logic [3:0] rxd_r, txd;
  logic [4:0] enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
    5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  int err_total = 0, cmp_count = 0, learn = 0;
  logic [10:0] key_h = '0;
  logic dq[$];
  logic [1:0] hq[$];
  logic [4:0] rq[$];

  fast_ethernet_symbol_codec #(.SOI_HALVES(SOI)) dut_u (.clk, .rst_n,
    .speed_100, .five_bit_host_mode, .transmit_carrier_echo_off,
    .float_pin_select, .status_clr, .ssd_err_r, .esd_err_r, .code_err_r,
    .line_clk, .rx_line_bit, .rx_locked, .link_pass, .tx_line_r,
    .tx_drive_r, .txd, .tx_en, .tx_er, .receive_float_or_jam_pin, .tx_clk,
    .rx_clk, .rxd_r, .rx_dv_r, .rx_er_r, .crs, .col, .rx_oe);
  mac_model mac_u (.tx_clk, .txd, .tx_en, .tx_er);

  initial forever #50 clk = ~clk;
  initial begin
    #37;
    forever #400 line_clk = ~line_clk;
  end

  // The key stream is learnt from idle and then predicted by its recurrence,
  // so no knowledge of the scrambler's phase is needed.
  always @(posedge line_clk) begin
    hq.push_back({tx_drive_r, tx_line_r});
    if (speed_100 && tx_drive_r === 1'b1) begin
      if (learn < 22) begin
        key_h = {key_h[9:0], ~tx_line_r};
        learn++;
      end else begin
        dq.push_back(tx_line_r ^ key_h[10] ^ key_h[8]);
        key_h = {key_h[9:0], key_h[10] ^ key_h[8]};
      end
    end
  end
  always @(negedge rx_clk) if (rx_dv_r === 1'b1) rq.push_back({rx_er_r, rxd_r});

  task automatic chk(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step
  function automatic logic [4:0] grp(input int i);
    return {dq[i], dq[i + 1], dq[i + 2], dq[i + 3], dq[i + 4]};
  endfunction : grp
  task automatic tx_check(input logic [4:0] eq[$]);
    int i;
    i = 0;
    while (i + 5 * eq.size() < dq.size() && grp(i) !== `SYM_SSD1) i++;
    foreach (eq[j]) chk("tx_group", grp(i + 5 * j), eq[j]);
  endtask : tx_check
  task automatic rx_send(input logic [4:0] g);
    for (int b = 4; b >= 0; b--) begin
      @(negedge line_clk);
      rx_line_bit = g[b];
    end
  endtask : rx_send
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #2000000;
    err_total++;
    end_of_test();
  end

  initial begin
    logic [4:0] eq[$];
    logic [3:0] nb[$];
    logic [4:0] rx_exp[6];
    logic ok, hit, bt;
    logic [7:0] bits10;
    logic [19:0] rx10;
    int i;
    step(16);
    rst_n = 1;
    step(400);
    nb = {4'h5, 4'h5};
    eq = {`SYM_SSD1, `SYM_SSD2};
    for (int n = 0; n < 16; n++) begin
      nb.push_back(4'(n));
      eq.push_back(enc[n]);
    end
    nb.push_back(4'hA);
    eq = {eq, `SYM_HALT, `SYM_ESD1, `SYM_ESD2, `SYM_IDLE, `SYM_IDLE};
    dq.delete();
    fork
      mac_u.send(nb, 18);
      begin
        step(300);
        chk("crs_echo", crs, 1);
      end
    join
    // The last idle group leaves the line about five group times after tx_en drops.
    step(300);
    tx_check(eq);
    transmit_carrier_echo_off = 1;
    fork
      mac_u.send({4'h5, 4'h5, 4'h1}, 9);
      begin
        step(150);
        chk("crs_echo_off", crs, 0);
      end
    join
    // Receive frame with one undefined group in the middle.
    @(negedge line_clk);
    rx_locked = 1;
    repeat (4) @(negedge line_clk);
    eq.delete();
    eq = {`SYM_IDLE, `SYM_SSD1, `SYM_SSD2, enc[3], enc[12], 5'h00, enc[7],
      `SYM_ESD1, `SYM_ESD2, `SYM_IDLE, `SYM_IDLE, `SYM_IDLE};
    foreach (eq[j]) rx_send(eq[j]);
    rx_exp = '{5'h05, 5'h05, 5'h03, 5'h0C, 5'h10, 5'h07};
    foreach (rx_exp[j]) chk("rx_nibble", rq[j], rx_exp[j]);
    for (i = 6; i < rq.size(); i++) chk("rx_end", rq[i], 5'h00);
    chk("code_err", code_err_r, 1);
    chk("ssd_err", ssd_err_r, 0);
    chk("esd_err", esd_err_r, 0);
    step(1);
    rx_locked = 0;
    status_clr = 1;
    step(4);
    status_clr = 0;
    step(2);
    chk("code_clr", code_err_r, 0);
    five_bit_host_mode = 1;
    link_pass = 1;
    step(20);
    chk("crs_pass", crs, 1);
    link_pass = 0;
    step(20);
    chk("crs_fail", crs, 0);
    mac_u.word(5'h10);
    step(40);
    dq.delete();
    step(320);
    ok = 0;
    for (int s = 0; s < 5; s++) begin
      hit = 1;
      for (int b = 0; b < 20; b++) begin
        hit &= (dq[dq.size() - 20 + b] === ((b + s) % 5 == 0));
      end
      ok |= hit;
    end
    chk("bypass_word", ok, 1);
    five_bit_host_mode = 0;
    float_pin_select = 1;
    receive_float_or_jam_pin = 0;
    step(10);
    chk("rx_float", rx_oe, 0);
    receive_float_or_jam_pin = 1;
    step(10);
    chk("rx_drive", rx_oe, 1);
    // 10 Mbps: halves are compared one line tick apart.
    rst_n = 0;
    speed_100 = 0;
    step(16);
    rst_n = 1;
    hq.delete();
    mac_u.send({4'hA, 4'h3}, 1);
    step(300);
    i = 0;
    while (i < hq.size() && hq[i][1] !== 1'b1) i++;
    bits10 = 8'h3A;
    for (int n = 0; n < 8; n++) begin
      bt = bits10[n];
      chk("half_a", hq[i + 2 * n], {1'b1, ~bt});
      chk("half_b", hq[i + 2 * n + 1], {1'b1, bt});
    end
    for (int h = 0; h < SOI; h++) chk("soi", hq[i + 16 + h], 2'h3);
    chk("soi_end", hq[i + 16 + SOI][1], 1'b0);
    // 10 Mbps receive: lock rises with the first half of the first cell,
    // and a whole cell of equal halves stands for the start of idle pulse.
    rx10 = 20'h0AD55;
    rq.delete();
    @(negedge line_clk);
    rx_locked = 1;
    for (int k = 0; k < 40; k++) begin
      if (k > 0) @(negedge line_clk);
      rx_line_bit = (k >= 32) | (rx10[k / 2] ^ (k % 2 == 0));
    end
    step(1);
    rx_locked = 0;
    chk("rx10_count", rq.size(), 4);
    for (int j = 0; j < 4; j++) begin
      chk("rx10_nibble", rq[j], rx10[4 * j +: 4]);
    end
    step(6);
    chk("rx_clk_idle", rx_clk, tx_clk);
    end_of_test();
  end
endmodule : fast_ethernet_symbol_codec_tb_top
